// >>> logic/dbf_pkg.sv
`default_nettype none
package dbf_pkg;
    localparam int DW = 16;
    localparam int GAIN_W = 4;
    localparam int CODE_W = 17;
    localparam int DIV_W = 8;
    localparam int ADDR_W = 4;
    localparam logic [1:0] MODE_DUAL = 2'h0;
    localparam logic [1:0] MODE_IL_FIRST = 2'h1;
    localparam logic [1:0] MODE_IL_SECOND = 2'h2;
    localparam logic [1:0] MODE_HALF = 2'h3;
    localparam logic MARK_A = 1'b1;
    localparam logic [CODE_W-1:0] FULL_SCALE = 17'h10000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int LINK_HALF_NS = 40;
    localparam int LINK_HALF_CYC = LINK_HALF_NS / CLK_PERIOD_NS;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_DATA_A = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_DATA_B = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_AFLAG = 2;
    localparam int CTRL_DUALCLK = 3;
    localparam int CTRL_ENABLE = 4;
    localparam int CTRL_W = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
    localparam logic [DW-1:0] DATA_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        CM_EXTERNAL,
        CM_DUAL,
        CM_DUAL_SYNC,
        CM_INVALID
    } dbf_clk_mode_t;
endpackage : dbf_pkg
`default_nettype wire

// >>> logic/dbf_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dbf_link_if;
    logic [dbf_pkg::DW-1:0] first_input_port;
    logic [dbf_pkg::DW-1:0] second_input_port;
    logic transmit_enable_input;
    logic dev_clk_o;
    logic dev_clk_oe_n;
    logic src_clk_o;
    logic src_clk_oe_n;
    logic src_clkc_o;
    logic src_clkc_oe_n;
    logic shared_clock_pin;
    logic shared_clock_complement_pin;
    // Weak pull-down when nobody drives
    assign shared_clock_pin = !dev_clk_oe_n ? dev_clk_o : (!src_clk_oe_n ? src_clk_o : 1'b0);
    assign shared_clock_complement_pin = !src_clkc_oe_n ? src_clkc_o : 1'b0;
    modport device (
        input first_input_port, second_input_port, transmit_enable_input,
        input shared_clock_pin, shared_clock_complement_pin,
        output dev_clk_o, dev_clk_oe_n
    );
    modport source (
        output first_input_port, second_input_port, transmit_enable_input,
        output src_clk_o, src_clk_oe_n, src_clkc_o, src_clkc_oe_n,
        input shared_clock_pin
    );
endinterface : dbf_link_if
`default_nettype wire

// >>> logic/dbf_source_end.sv
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dbf_source_end #(
    parameter int HALF_CYC = dbf_pkg::LINK_HALF_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [dbf_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [dbf_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    dbf_link_if.source lnk
);
    import dbf_pkg::*;

    logic [CTRL_W-1:0] ctrl, next_ctrl;
    logic [DW-1:0] data_a, next_data_a, data_b, next_data_b;
    logic aw_got, next_aw_got, w_got, next_w_got;
    logic [ADDR_W-1:0] waddr, next_waddr;
    logic [31:0] wdata, next_wdata;
    logic [3:0] wstrb, next_wstrb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [DW-1:0] sent_cnt, next_sent_cnt;

    always_comb begin
        next_ctrl = ctrl;
        next_data_a = data_a;
        next_data_b = data_b;
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_waddr = waddr;
        next_wdata = wdata;
        next_wstrb = wstrb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_got = 1'b1;
            next_waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_got = 1'b1;
            next_wdata = s_axi_wdata;
            next_wstrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_got && w_got && !s_axi_bvalid) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            case (waddr)
                OFS_CTRL: if (wstrb[0]) next_ctrl = wdata[CTRL_W-1:0];
                OFS_DATA_A: for (int i = 0; i < 2; i++) begin
                    if (wstrb[i]) next_data_a[8*i +: 8] = wdata[8*i +: 8];
                end
                OFS_DATA_B: for (int i = 0; i < 2; i++) begin
                    if (wstrb[i]) next_data_b[8*i +: 8] = wdata[8*i +: 8];
                end
                OFS_STATUS: ;
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            case (s_axi_araddr)
                OFS_CTRL: next_rdata = {27'h0000000, ctrl};
                OFS_DATA_A: next_rdata = {16'h0000, data_a};
                OFS_DATA_B: next_rdata = {16'h0000, data_b};
                OFS_STATUS: next_rdata = {16'h0000, sent_cnt};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_aw_got && !next_bvalid;
        next_wready = !next_w_got && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
            data_a <= DATA_RESET;
            data_b <= DATA_RESET;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            waddr <= '0;
            wdata <= '0;
            wstrb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            ctrl <= next_ctrl;
            data_a <= next_data_a;
            data_b <= next_data_b;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            waddr <= next_waddr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // Link side: own divider in dual clock mode, else follow the device clock
    logic [1:0] mode;
    logic make_clk, enable, pin_s1, pin_s2, pin_prev, gen_clk, next_gen_clk, fall;
    logic [DIV_W-1:0] div_cnt, next_div_cnt;
    logic phase_b, next_phase_b, next_txen;
    logic [DW-1:0] next_da, next_db;

    assign mode = ctrl[CTRL_MODE_LSB +: 2];
    assign make_clk = ctrl[CTRL_DUALCLK];
    assign enable = ctrl[CTRL_ENABLE];
    assign lnk.src_clk_o = gen_clk;

    always_comb begin
        next_div_cnt = div_cnt + 1'b1;
        next_gen_clk = gen_clk;
        if (!make_clk) begin
            next_div_cnt = '0;
            next_gen_clk = 1'b0;
        end else if (div_cnt == DIV_W'(HALF_CYC - 1)) begin
            next_div_cnt = '0;
            next_gen_clk = !gen_clk;
        end
        // Data moves on the falling edge so the device's rising edge sees it settled
        fall = make_clk ? (gen_clk && !next_gen_clk) : (pin_prev && !pin_s2);
        next_da = lnk.first_input_port;
        next_db = lnk.second_input_port;
        next_txen = lnk.transmit_enable_input;
        next_phase_b = phase_b;
        next_sent_cnt = sent_cnt;
        if (!enable) begin
            next_txen = 1'b0;
            next_phase_b = 1'b0;
        end else if (fall) begin
            next_sent_cnt = sent_cnt + 1'b1;
            next_txen = 1'b1;
            case (mode)
                MODE_DUAL, MODE_HALF: begin
                    next_da = data_a;
                    next_db = data_b;
                end
                MODE_IL_FIRST: begin
                    next_da = phase_b ? data_b : data_a;
                    next_db = {phase_b ? !MARK_A : MARK_A, 15'h0000};
                    next_phase_b = !phase_b;
                end
                MODE_IL_SECOND: begin
                    next_db = phase_b ? data_b : data_a;
                    next_da = {phase_b ? !MARK_A : MARK_A, 15'h0000};
                    next_phase_b = !phase_b;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_prev <= 1'b0;
            div_cnt <= '0;
            gen_clk <= 1'b0;
            lnk.src_clkc_o <= 1'b1;
            lnk.src_clk_oe_n <= 1'b1;
            lnk.src_clkc_oe_n <= 1'b1;
            lnk.first_input_port <= '0;
            lnk.second_input_port <= '0;
            lnk.transmit_enable_input <= 1'b0;
            phase_b <= 1'b0;
            sent_cnt <= '0;
        end else begin
            pin_s1 <= lnk.shared_clock_pin;
            pin_s2 <= pin_s1;
            pin_prev <= pin_s2;
            div_cnt <= next_div_cnt;
            gen_clk <= next_gen_clk;
            // Own flop so the complement leg is not a gate output
            lnk.src_clkc_o <= !next_gen_clk;
            lnk.src_clk_oe_n <= !make_clk;
            lnk.src_clkc_oe_n <= !make_clk;
            lnk.first_input_port <= next_da;
            lnk.second_input_port <= next_db;
            lnk.transmit_enable_input <= next_txen;
            phase_b <= next_phase_b;
            sent_cnt <= next_sent_cnt;
        end
    end
endmodule : dbf_source_end
`default_nettype wire

// >>> logic/dbf_device_end.sv
`timescale 1ns/1ps
`default_nettype none
module dbf_device_end #(
    parameter int HALF_CYC = dbf_pkg::LINK_HALF_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    dbf_link_if.device lnk,
    input wire logic [1:0] input_select_mode,
    input wire logic aflag_sel,
    input wire logic dualclk_ena,
    input wire logic clko_off,
    input wire logic synchr_clkin,
    input wire logic input_threshold_select_bit,
    input wire logic [dbf_pkg::GAIN_W-1:0] coarse_gain_a,
    input wire logic [dbf_pkg::GAIN_W-1:0] coarse_gain_b,
    output logic [dbf_pkg::DW-1:0] chan_a_data,
    output logic chan_a_valid,
    output logic [dbf_pkg::DW-1:0] chan_b_data,
    output logic chan_b_valid,
    output logic [dbf_pkg::CODE_W-1:0] chan_a_comp,
    output logic [dbf_pkg::CODE_W-1:0] chan_b_comp,
    output logic [dbf_pkg::GAIN_W:0] full_scale_mult_a,
    output logic [dbf_pkg::GAIN_W:0] full_scale_mult_b,
    output logic io_thresh_1p8,
    output var dbf_pkg::dbf_clk_mode_t clock_mode
);
    import dbf_pkg::*;

    // Pin synchronisers; data, enable and clock share one latency
    logic [DW-1:0] da_s1, da_s2, db_s1, db_s2;
    logic [2:0] pin_s1, pin_s2;
    logic txen_s, clkp_s, clkn_s;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            da_s1 <= '0;
            da_s2 <= '0;
            db_s1 <= '0;
            db_s2 <= '0;
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            da_s1 <= lnk.first_input_port;
            da_s2 <= da_s1;
            db_s1 <= lnk.second_input_port;
            db_s2 <= db_s1;
            pin_s1 <= {lnk.transmit_enable_input, lnk.shared_clock_pin,
                       lnk.shared_clock_complement_pin};
            pin_s2 <= pin_s1;
        end
    end

    assign txen_s = pin_s2[2];
    assign clkp_s = pin_s2[1];
    assign clkn_s = pin_s2[0];

    // Data clock: generated and driven out, or received differentially
    logic drive_clk, gen_clk, next_gen_clk, next_oe_n;
    logic [DIV_W-1:0] div_cnt, next_div_cnt;
    logic lvl, next_lvl, lvl_prev, strobe;

    assign lnk.dev_clk_o = gen_clk;

    always_comb begin
        drive_clk = !dualclk_ena && !clko_off;
        next_oe_n = !drive_clk;
        next_div_cnt = div_cnt + 1'b1;
        next_gen_clk = gen_clk;
        if (!drive_clk) begin
            next_div_cnt = '0;
            next_gen_clk = 1'b0;
        end else if (div_cnt == DIV_W'(HALF_CYC - 1)) begin
            next_div_cnt = '0;
            next_gen_clk = !gen_clk;
        end
        // Equal legs mean a glitch or an idle pair, so the last level is kept
        next_lvl = (clkp_s != clkn_s) ? clkp_s : lvl;
        strobe = (dualclk_ena && lvl && !lvl_prev)
            || (drive_clk && !gen_clk && next_gen_clk);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= '0;
            gen_clk <= 1'b0;
            lnk.dev_clk_oe_n <= 1'b1;
            lvl <= 1'b0;
            lvl_prev <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            gen_clk <= next_gen_clk;
            lnk.dev_clk_oe_n <= next_oe_n;
            lvl <= next_lvl;
            lvl_prev <= lvl;
        end
    end

    // Input formatting
    logic [DW-1:0] il_word, half_word, next_half_word;
    logic [DW-1:0] next_a, next_b;
    logic next_a_valid, next_b_valid;
    logic marker, txen_prev, next_txen_prev, txen_rise;
    logic phase_b, next_phase_b, half_pend, next_half_pend;
    logic take, word_is_a;

    always_comb begin
        next_a = chan_a_data;
        next_b = chan_b_data;
        next_a_valid = 1'b0;
        next_b_valid = 1'b0;
        next_txen_prev = txen_prev;
        next_phase_b = phase_b;
        next_half_pend = 1'b0;
        next_half_word = half_word;
        il_word = (input_select_mode == MODE_IL_SECOND) ? db_s2 : da_s2;
        marker = (input_select_mode == MODE_IL_SECOND) ? da_s2[DW-1] : db_s2[DW-1];
        txen_rise = txen_s && !txen_prev;
        take = 1'b0;
        word_is_a = 1'b0;
        if (half_pend) begin
            // Second half of a half-rate pair follows one cycle after the first
            next_a = half_word;
            next_a_valid = 1'b1;
        end
        if (strobe) begin
            next_txen_prev = txen_s;
            case (input_select_mode)
                MODE_DUAL: begin
                    next_a = da_s2;
                    next_b = db_s2;
                    next_a_valid = 1'b1;
                    next_b_valid = 1'b1;
                end
                MODE_IL_FIRST, MODE_IL_SECOND: begin
                    if (aflag_sel) begin
                        take = txen_s;
                        word_is_a = txen_rise || !phase_b;
                        next_phase_b = txen_s && word_is_a;
                    end else begin
                        take = 1'b1;
                        word_is_a = (marker == MARK_A);
                    end
                    if (take && word_is_a) begin
                        next_a = il_word;
                        next_a_valid = 1'b1;
                    end else if (take) begin
                        next_b = il_word;
                        next_b_valid = 1'b1;
                    end
                end
                MODE_HALF: begin
                    next_a = da_s2;
                    next_a_valid = 1'b1;
                    next_half_pend = 1'b1;
                    next_half_word = db_s2;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_a_data <= '0;
            chan_b_data <= '0;
            chan_a_valid <= 1'b0;
            chan_b_valid <= 1'b0;
            chan_a_comp <= FULL_SCALE;
            chan_b_comp <= FULL_SCALE;
            txen_prev <= 1'b0;
            phase_b <= 1'b0;
            half_pend <= 1'b0;
            half_word <= '0;
        end else begin
            chan_a_data <= next_a;
            chan_b_data <= next_b;
            chan_a_valid <= next_a_valid;
            chan_b_valid <= next_b_valid;
            // Offset binary: complementary share is the rest of the scale
            chan_a_comp <= FULL_SCALE - {1'b0, next_a};
            chan_b_comp <= FULL_SCALE - {1'b0, next_b};
            txen_prev <= next_txen_prev;
            phase_b <= next_phase_b;
            half_pend <= next_half_pend;
            half_word <= next_half_word;
        end
    end

    // Static configuration decode
    logic next_thresh;
    logic [GAIN_W:0] next_mult_a, next_mult_b;
    dbf_clk_mode_t next_clock_mode;

    always_comb begin
        next_thresh = input_threshold_select_bit;
        next_mult_a = {1'b0, coarse_gain_a} + 1'b1;
        next_mult_b = {1'b0, coarse_gain_b} + 1'b1;
        case ({synchr_clkin, clko_off, dualclk_ena})
            3'h7: next_clock_mode = CM_DUAL_SYNC;
            3'h3: next_clock_mode = CM_DUAL;
            3'h0: next_clock_mode = CM_EXTERNAL;
            default: next_clock_mode = CM_INVALID;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_thresh_1p8 <= 1'b0;
            full_scale_mult_a <= '0;
            full_scale_mult_b <= '0;
            clock_mode <= CM_EXTERNAL;
        end else begin
            io_thresh_1p8 <= next_thresh;
            full_scale_mult_a <= next_mult_a;
            full_scale_mult_b <= next_mult_b;
            clock_mode <= next_clock_mode;
        end
    end
endmodule : dbf_device_end
`default_nettype wire

// >>> testbench/dbf_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dbf_link_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [dbf_pkg::DW-1:0] first_input_port,
    input wire logic [dbf_pkg::DW-1:0] second_input_port,
    input wire logic transmit_enable_input,
    input wire logic dev_clk_o,
    input wire logic dev_clk_oe_n,
    input wire logic src_clk_oe_n,
    input wire logic src_clkc_oe_n,
    input wire logic shared_clock_pin,
    input wire logic shared_clock_complement_pin
);
    import dbf_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Phases assume the default divider of eight cycles
    sequence s_high;
        dev_clk_o [*8];
    endsequence
    sequence s_low;
        (!dev_clk_o) [*8];
    endsequence
    property p_clk_high;
        disable iff (!aresetn || dev_clk_oe_n) $rose(dev_clk_o) |-> s_high ##1 !dev_clk_o;
    endproperty
    property p_clk_low;
        disable iff (!aresetn || dev_clk_oe_n) $fell(dev_clk_o) |-> s_low ##1 dev_clk_o;
    endproperty
    property p_no_fight;
        !(!dev_clk_oe_n && !src_clk_oe_n);
    endproperty
    property p_pull_down;
        dev_clk_oe_n && src_clk_oe_n |-> !shared_clock_pin;
    endproperty
    property p_diff_legs;
        !src_clk_oe_n && !src_clkc_oe_n |-> shared_clock_pin != shared_clock_complement_pin;
    endproperty
    // Words move on the falling edge so the rising edge sees settled data
    property p_word_edge;
        transmit_enable_input && ($changed(first_input_port) || $changed(second_input_port))
            |-> !shared_clock_pin;
    endproperty
    property p_txen_edge;
        $rose(transmit_enable_input) |-> !shared_clock_pin;
    endproperty
    property p_reset_oe;
        $rose(aresetn) |-> dev_clk_oe_n;
    endproperty
    a_clk_high: assert property (p_clk_high)
        else $error("clock high phase wrong");
    a_clk_low: assert property (p_clk_low)
        else $error("clock low phase wrong");
    a_no_fight: assert property (p_no_fight)
        else $error("two drivers on clock pin");
    a_pull_down: assert property (p_pull_down)
        else $error("undriven pin not low");
    a_diff_legs: assert property (p_diff_legs)
        else $error("clock legs equal");
    a_word_edge: assert property (p_word_edge)
        else $error("word changed while clock high");
    a_txen_edge: assert property (p_txen_edge)
        else $error("enable rose while clock high");
    a_reset_oe: assert property (p_reset_oe)
        else $error("pin driven at reset release");
endmodule : dbf_link_sva
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dbf_pkg::*;
    localparam dbf_clk_mode_t CM_TAB [8] = '{CM_EXTERNAL, CM_INVALID, CM_INVALID, CM_DUAL,
        CM_INVALID, CM_INVALID, CM_INVALID, CM_DUAL_SYNC};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic awr, wr, bv, arr, rv, a_v, b_v, thr_o, k;
    logic [3:0] awa = 4'h0, ara = 4'h0, ga = 4'h0, gb = 4'h0;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0] br, rr, mode = 2'h0;
    logic af = 1'b0, dc = 1'b0, co = 1'b0, sy = 1'b0, thr = 1'b0;
    logic [15:0] a_d, b_d, ea, eb, x, y, w;
    logic [16:0] a_c, b_c;
    logic [4:0] m_a, m_b;
    dbf_clk_mode_t cm;
    logic [15:0] qa[$], qb[$];
    int fail_count = 0, checks_done = 0, wm = 0, seed = 32'hfe42;
    dbf_link_if lnk ();
    dbf_source_end u_dbf_source_end (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr), .lnk(lnk));
    dbf_device_end u_dbf_device_end (.aclk(aclk), .aresetn(aresetn), .lnk(lnk),
        .input_select_mode(mode), .aflag_sel(af), .dualclk_ena(dc), .clko_off(co),
        .synchr_clkin(sy), .input_threshold_select_bit(thr), .coarse_gain_a(ga),
        .coarse_gain_b(gb), .chan_a_data(a_d), .chan_a_valid(a_v), .chan_b_data(b_d),
        .chan_b_valid(b_v), .chan_a_comp(a_c), .chan_b_comp(b_c), .full_scale_mult_a(m_a),
        .full_scale_mult_b(m_b), .io_thresh_1p8(thr_o), .clock_mode(cm));
    dbf_link_sva u_dbf_link_sva (.aclk(aclk), .aresetn(aresetn),
        .first_input_port(lnk.first_input_port), .second_input_port(lnk.second_input_port),
        .transmit_enable_input(lnk.transmit_enable_input), .dev_clk_o(lnk.dev_clk_o),
        .dev_clk_oe_n(lnk.dev_clk_oe_n), .src_clk_oe_n(lnk.src_clk_oe_n),
        .src_clkc_oe_n(lnk.src_clkc_oe_n), .shared_clock_pin(lnk.shared_clock_pin),
        .shared_clock_complement_pin(lnk.shared_clock_complement_pin));
    always #2.5 aclk = ~aclk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    task automatic lim(input int n);
        if (n >= 300) begin
            fail_count++;
            summarize();
        end
    endtask : lim
    task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awa <= ad;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv && n < 300);
        chk("bresp", br, er);
        bre <= 1'b0;
        @(posedge aclk);
        lim(n);
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] ad, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        ara <= ad;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arr) arv <= 1'b0;
        end while (!rv && n < 300);
        chk("rdata", rd, e);
        chk("rresp", rr, er);
        rre <= 1'b0;
        @(posedge aclk);
        lim(n);
    endtask : axi_rd
    task automatic run(input logic [1:0] md, input logic fl, input logic dk);
        int n;
        axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
        repeat (40) @(posedge aclk);
        mode <= md;
        af <= fl;
        dc <= dk;
        co <= dk;
        ga <= $random(seed);
        gb <= $random(seed);
        thr <= $random(seed);
        x = $random(seed);
        y = x ^ 16'h8421;
        // Upper lanes carry junk that must not reach the port
        axi_wr(OFS_DATA_A, {~x, x}, RESP_OKAY);
        axi_wr(OFS_DATA_B, {x, y}, RESP_OKAY);
        axi_rd(OFS_DATA_A, {16'h0, x}, RESP_OKAY);
        axi_wr(OFS_CTRL, {28'h1, dk, fl, md}, RESP_OKAY);
        axi_rd(OFS_CTRL, {28'h1, dk, fl, md}, RESP_OKAY);
        repeat (96) @(posedge aclk);
        chk("gain_a", m_a, ga + 5'h1);
        chk("gain_b", m_b, gb + 5'h1);
        chk("thresh", thr_o, thr);
        wm <= md == MODE_DUAL ? 1 : fl ? 0 : md == MODE_IL_FIRST ? 2 : md == MODE_IL_SECOND ? 3 : 0;
        if (md == MODE_HALF) begin
            n = 0;
            while (a_v !== 1'b1 && n < 300) begin
                @(posedge aclk);
                n++;
            end
            lim(n);
            // Skip the rest of this pair so the next pulse starts a new one
            repeat (2) @(posedge aclk);
            qa.push_back(x);
            qa.push_back(y);
        end else begin
            qa.push_back(x);
            qb.push_back(y);
        end
        n = 0;
        while (qa.size() + qb.size() > 0 && n < 300) begin
            @(posedge aclk);
            n++;
        end
        lim(n);
        wm <= 0;
    endtask : run
    always @(posedge aclk) begin
        if (a_v === 1'b1 && qa.size() > 0) begin
            ea = qa.pop_front();
            chk("chan_a", a_d, ea);
            chk("comp_a", a_c, FULL_SCALE - {1'b0, ea});
        end
        if (b_v === 1'b1 && qb.size() > 0) begin
            eb = qb.pop_front();
            chk("chan_b", b_d, eb);
            chk("comp_b", b_c, FULL_SCALE - {1'b0, eb});
        end
        if (b_v === 1'b1 && mode == MODE_HALF) chk("b_idle", b_v, 1'b0);
        if (wm == 1 && lnk.transmit_enable_input === 1'b1) begin
            chk("dual_a", lnk.first_input_port, x);
            chk("dual_b", lnk.second_input_port, y);
        end
        if (wm > 1 && lnk.transmit_enable_input === 1'b1) begin
            w = wm == 2 ? lnk.first_input_port : lnk.second_input_port;
            k = wm == 2 ? lnk.second_input_port[15] : lnk.first_input_port[15];
            chk("marker", k, w == x);
        end
    end
    initial begin
        int n;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk("mode_rst", cm, CM_EXTERNAL);
        axi_wr(4'h2, 32'h1, RESP_SLVERR);
        axi_rd(4'h2, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            {sy, co, dc} <= i[2:0];
            repeat (3) @(posedge aclk);
            chk("clk_mode", cm, CM_TAB[i]);
        end
        sy <= 1'b0;
        run(MODE_DUAL, 1'b0, 1'b0);
        run(MODE_IL_FIRST, 1'b0, 1'b0);
        run(MODE_IL_SECOND, 1'b0, 1'b0);
        run(MODE_IL_FIRST, 1'b1, 1'b0);
        run(MODE_HALF, 1'b0, 1'b0);
        run(MODE_DUAL, 1'b0, 1'b1);
        run(MODE_IL_SECOND, 1'b1, 1'b1);
        axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
        dc <= 1'b0;
        co <= 1'b1;
        axi_wr(OFS_CTRL, 32'h10, RESP_OKAY);
        for (int j = 0; j < 2; j++) begin
            n = 0;
            repeat (100) begin
                @(posedge aclk);
                n += a_v;
            end
            chk("strobes", n != 0, j);
            co <= 1'b0;
        end
        summarize();
    end
endmodule : tb
`default_nettype wire
